// *** design/complementary_pwm_output_control.sv ***
// ----------------------------------------------------------------
// Complementary PWM output control
// ----------------------------------------------------------------
// Holds the registers, the triangle or sawtooth counter, dead time, level select,
// forced cutoff and output disable of eight timer pins.
// Assumes a plain 8-bit register port and a 100 MHz ref_clk.
//
// Contract
// - Lockstep bit makes both counters run together
// - Counter-phase select: 0 active low, 1 active high
// - Normal-phase select: 0 active low, 1 active high
// - Level selects ignored in timer mode
// - Mode 00 timer, 01 reset-synchronous PWM
// - Mode 10 complementary, transfer on underflow
// - Mode 11 complementary, transfer on period match
// - Cutoff field: none, hi-z, low, high
// - Per-channel cutoff fields A, B, C, D
// - Disable bit returns pin to general I/O
// - Count source select with forbidden codes
// - Wrap enable gates wrap flags to request
// - Match enables gate match flags to requests
// - Start flags start and stop counters
// - Buffer select makes D0 buffer of B0
`include "pwm_consts.svh"
module complementary_pwm_output_control
  import pwm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Register port
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata_r,
  // External pins
  input wire logic external_count_clock,
  input wire logic cutoff_pin,
  // Timer pins A0 B0 C0 D0 A1 B1 C1 D1 in bits 0 to 7
  output logic [7:0] pin_out_r,
  output logic [7:0] pin_oe_n_r,
  output logic [7:0] gpio_sel_r,
  // Interrupt requests
  output logic [3:0] match_irq_r,
  output logic wrap_irq_r
);
  logic [7:0] func_r;
  logic [7:0] cut0_r;
  logic [7:0] cut1_r;
  logic [7:0] out_dis_r;
  logic [7:0] count_ctl_r;
  logic [7:0] irq_en_r;
  logic [1:0] run_r;
  logic [7:0] tmode_r;
  logic [5:0] flag_r;
  logic [15:0] period_r;
  logic [15:0] cmpb_r;
  logic [15:0] bufd_r;
  logic [15:0] dead_r;
  logic [15:0] cnt_r;
  logic [15:0] dt_cnt_r;
  count_state_t st_r;
  logic pwm_prev_r;
  logic half_r;
  logic [2:0] cut_sync_r;
  logic cut_lvl_r;
  logic tick;
  combo_mode_t mode;
  logic running;
  logic is_comp;
  logic ev_period;
  logic ev_under;
  logic ev_match_b;
  logic xfer;
  logic pwm_raw;
  logic settled;
  logic nph_act;
  logic cph_act;
  logic nph_lvl;
  logic cph_lvl;
  logic [7:0] wave;
  logic [5:0] flag_set;
  logic [7:0] rdata_nxt;

  // ----------------------------------------------------------------
  // Count source
  // ----------------------------------------------------------------
  count_source u_src (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .src_sel(count_ctl_r[2:0]),
    .external_count_clock(external_count_clock),
    .tick_r(tick)
  );

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  assign mode = combo_mode_t'(func_r[1:0]);
  assign is_comp = func_r[1];

  // Configuration registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      func_r <= `R_ZERO8;
      cut0_r <= `R_ZERO8;
      cut1_r <= `R_ZERO8;
      out_dis_r <= `R_OUT_DIS;
      count_ctl_r <= `R_ZERO8;
      irq_en_r <= `R_ZERO8;
      tmode_r <= `R_ZERO8;
      period_r <= `R_PERIOD;
      bufd_r <= `R_ZERO16;
      dead_r <= `R_ZERO16;
    end else if (wr) begin
      unique case (addr)
        `A_FUNC_CTL: func_r <= wdata;
        `A_CUT0: cut0_r <= wdata;
        `A_CUT1: cut1_r <= wdata;
        `A_OUT_DIS: out_dis_r <= wdata;
        `A_COUNT_CTL: count_ctl_r <= wdata;
        `A_IRQ_EN: irq_en_r <= {3'h0, wdata[4:0]};
        `A_TMODE: tmode_r <= wdata;
        `A_PERIOD_L: period_r[7:0] <= wdata;
        `A_PERIOD_H: period_r[15:8] <= wdata;
        `A_BUFD_L: bufd_r[7:0] <= wdata;
        `A_BUFD_H: bufd_r[15:8] <= wdata;
        `A_DEAD_L: dead_r[7:0] <= wdata;
        `A_DEAD_H: dead_r[15:8] <= wdata;
        default: ;
      endcase
    end
  end

  // Start flags; lockstep mirrors a start onto both counters
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      run_r <= 2'h0;
    end else if (wr && addr == `A_RUN) begin
      if (tmode_r[`F_LOCKSTEP]) begin
        run_r <= {2{wdata[0] | wdata[1]}};
      end else begin
        run_r <= wdata[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Complementary mode needs both counters started
  assign running = run_r[0] & (run_r[1] | ~is_comp);
  assign ev_period = tick && running && (st_r == ST_UP) && (cnt_r == period_r);
  assign ev_under = tick && running && (st_r == ST_DOWN) && (cnt_r == `R_ZERO16);
  assign ev_match_b = tick && running && (cnt_r == cmpb_r);

  // Triangle in complementary modes, sawtooth otherwise
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= ST_STOP;
      cnt_r <= `R_ZERO16;
    end else if (!running) begin
      st_r <= ST_STOP;
    end else if (tick) begin
      unique case (st_r)
        ST_STOP: begin
          st_r <= ST_UP;
        end
        ST_UP: begin
          if (cnt_r == period_r && is_comp) begin
            st_r <= ST_DOWN;
            cnt_r <= cnt_r - 16'h0001;
          end else if (cnt_r == period_r) begin
            cnt_r <= `R_ZERO16;
          end else begin
            cnt_r <= cnt_r + 16'h0001;
          end
        end
        ST_DOWN: begin
          if (cnt_r == `R_ZERO16) begin
            st_r <= ST_UP;
            cnt_r <= cnt_r + 16'h0001;
          end else begin
            cnt_r <= cnt_r - 16'h0001;
          end
        end
      endcase
    end
  end

  // Buffer to compare transfer, moment set by the mode
  assign xfer = tmode_r[`F_BUF_D0] && ((mode == MODE_COMP_UNDER && ev_under)
    || (mode == MODE_COMP_MATCH && ev_period));

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cmpb_r <= `R_ZERO16;
    end else if (xfer) begin
      cmpb_r <= bufd_r;
    end else if (wr && addr == `A_CMPB_L) begin
      cmpb_r[7:0] <= wdata;
    end else if (wr && addr == `A_CMPB_H) begin
      cmpb_r[15:8] <= wdata;
    end
  end

  // ----------------------------------------------------------------
  // Flags and requests
  // ----------------------------------------------------------------
  assign flag_set = {ev_under, ev_period & ~is_comp, 2'h0, ev_match_b, ev_period};

  // Writing 0 clears a flag; a new event in the same cycle wins
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flag_r <= 6'h00;
    end else if (wr && addr == `A_STATUS) begin
      flag_r <= (flag_r & wdata[5:0]) | flag_set;
    end else begin
      flag_r <= flag_r | flag_set;
    end
  end

  // Requests gated by their enables
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      match_irq_r <= 4'h0;
      wrap_irq_r <= 1'b0;
    end else begin
      match_irq_r <= flag_r[3:0] & irq_en_r[3:0];
      wrap_irq_r <= (flag_r[`F_UP_FLAG] | flag_r[`F_DOWN_FLAG]) & irq_en_r[`F_WRAP_IE];
    end
  end

  // ----------------------------------------------------------------
  // Waveform and dead time
  // ----------------------------------------------------------------
  assign pwm_raw = running && (cnt_r < cmpb_r);
  // A fresh edge is never settled, so the pair has a gap of dead ticks
  assign settled = (dt_cnt_r == dead_r) && (pwm_raw == pwm_prev_r);
  assign nph_act = running && pwm_raw && settled;
  assign cph_act = running && !pwm_raw && settled;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pwm_prev_r <= 1'b0;
      dt_cnt_r <= `R_ZERO16;
      half_r <= 1'b0;
    end else begin
      pwm_prev_r <= pwm_raw;
      if (pwm_raw != pwm_prev_r) begin
        dt_cnt_r <= `R_ZERO16;
      end else if (tick && dt_cnt_r != dead_r) begin
        dt_cnt_r <= dt_cnt_r + 16'h0001;
      end
      if (ev_period || ev_under) begin
        half_r <= ~half_r;
      end
    end
  end

  // Active level: select 1 is active high, 0 active low (initial = inactive)
  assign nph_lvl = func_r[`F_NPH_LVL] ? nph_act : ~nph_act;
  assign cph_lvl = func_r[`F_CPH_LVL] ? cph_act : ~cph_act;

  // Pin map; timer mode passes the raw wave and ignores level selects
  always_comb begin
    if (mode == MODE_TIMER) begin
      wave = {8{pwm_raw}};
    end else begin
      wave = {cph_lvl, cph_lvl, nph_lvl, nph_lvl, cph_lvl, half_r, nph_lvl, nph_lvl};
    end
  end

  // ----------------------------------------------------------------
  // Cutoff and output stage
  // ----------------------------------------------------------------
  // Cutoff pin: three flops, acts without waiting for a count enable
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cut_sync_r <= 3'h0;
      cut_lvl_r <= 1'b0;
    end else begin
      cut_sync_r <= {cut_sync_r[1:0], cutoff_pin};
      if (cut_sync_r[1] == cut_sync_r[2]) begin
        cut_lvl_r <= cut_sync_r[2];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      logic [1:0] fld;
      // Field A in bits 7:6 down to D in bits 1:0
      assign fld = (gi < 4) ? cut0_r[7 - 2 * (gi % 4) -: 2] : cut1_r[7 - 2 * (gi % 4) -: 2];
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          pin_out_r[gi] <= 1'b0;
          pin_oe_n_r[gi] <= 1'b1;
          gpio_sel_r[gi] <= 1'b1;
        end else if (out_dis_r[gi]) begin
          pin_out_r[gi] <= 1'b0;
          pin_oe_n_r[gi] <= 1'b1;
          gpio_sel_r[gi] <= 1'b1;
        end else begin
          gpio_sel_r[gi] <= 1'b0;
          if (cut_lvl_r && fld != `CUT_NONE) begin
            pin_out_r[gi] <= (fld == `CUT_HIGH);
            pin_oe_n_r[gi] <= (fld == `CUT_HIZ);
          end else begin
            pin_out_r[gi] <= wave[gi];
            pin_oe_n_r[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_comb begin
    unique case (addr)
      `A_FUNC_CTL: rdata_nxt = func_r;
      `A_CUT0: rdata_nxt = cut0_r;
      `A_CUT1: rdata_nxt = cut1_r;
      `A_OUT_DIS: rdata_nxt = out_dis_r;
      `A_COUNT_CTL: rdata_nxt = count_ctl_r;
      `A_IRQ_EN: rdata_nxt = irq_en_r;
      `A_RUN: rdata_nxt = {6'h00, run_r};
      `A_TMODE: rdata_nxt = tmode_r;
      `A_STATUS: rdata_nxt = {2'h0, flag_r};
      `A_PERIOD_L: rdata_nxt = period_r[7:0];
      `A_PERIOD_H: rdata_nxt = period_r[15:8];
      `A_CMPB_L: rdata_nxt = cmpb_r[7:0];
      `A_CMPB_H: rdata_nxt = cmpb_r[15:8];
      `A_BUFD_L: rdata_nxt = bufd_r[7:0];
      `A_BUFD_H: rdata_nxt = bufd_r[15:8];
      `A_DEAD_L: rdata_nxt = dead_r[7:0];
      `A_DEAD_H: rdata_nxt = dead_r[15:8];
      `A_COUNT_L: rdata_nxt = cnt_r[7:0];
      `A_COUNT_H: rdata_nxt = cnt_r[15:8];
      default: rdata_nxt = `R_ZERO8;
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= `R_ZERO8;
    end else begin
      rdata_r <= rd ? rdata_nxt : `R_ZERO8;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_pair_exclusive: assert property (@(posedge ref_clk) disable iff (!rstn)
    !(nph_act && cph_act)) else $error("pair phases active together");
  a_xfer_under: assert property (@(posedge ref_clk) disable iff (!rstn)
    (mode == MODE_COMP_UNDER && ev_under && tmode_r[`F_BUF_D0]) |=> cmpb_r == $past(bufd_r))
    else $error("no transfer on underflow");
  a_xfer_match: assert property (@(posedge ref_clk) disable iff (!rstn)
    (mode == MODE_COMP_MATCH && ev_period && tmode_r[`F_BUF_D0]) |=> cmpb_r == $past(bufd_r))
    else $error("no transfer on period match");
  a_cutoff_low: assert property (@(posedge ref_clk) disable iff (!rstn)
    (cut_lvl_r && !out_dis_r[1] && cut0_r[5:4] == `CUT_LOW) |=> !pin_out_r[1] && !pin_oe_n_r[1])
    else $error("cutoff low not driven");
  a_disable_gpio: assert property (@(posedge ref_clk) disable iff (!rstn)
    out_dis_r[0] |=> gpio_sel_r[0] && pin_oe_n_r[0]) else $error("disabled pin still timer");
  a_wrap_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
    !irq_en_r[`F_WRAP_IE] |=> !wrap_irq_r) else $error("wrap request not blocked");
  a_match_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
    (flag_r[0] && irq_en_r[0]) |=> match_irq_r[0]) else $error("match request missing");
  a_timer_raw: assert property (@(posedge ref_clk) disable iff (!rstn)
    (mode == MODE_TIMER && !out_dis_r[1] && !cut_lvl_r) |=> pin_out_r[1] == $past(pwm_raw))
    else $error("level select acted in timer mode");
  a_cph_level: assert property (@(posedge ref_clk) disable iff (!rstn)
    (mode != MODE_TIMER && !out_dis_r[3] && !cut_lvl_r) |=> pin_out_r[3] == $past(cph_lvl))
    else $error("counter phase level wrong");
  a_forbidden_src: assert property (@(posedge ref_clk) disable iff (!rstn)
    (count_ctl_r[2:1] == 2'h3) [*3] |-> !tick) else $error("tick from forbidden source");
  c_underflow: cover property (@(posedge ref_clk) disable iff (!rstn) ev_under && xfer);
  c_cutoff: cover property (@(posedge ref_clk) disable iff (!rstn) cut_lvl_r && cut0_r != 8'h00);
  c_dead_gap: cover property (@(posedge ref_clk) disable iff (!rstn) is_comp && running && !settled);
endmodule

// *** design/count_source.sv ***
// ----------------------------------------------------------------
// Count source prescaler
// ----------------------------------------------------------------
// Makes the one-cycle count enable from the peripheral clock or from
// the external count clock pin. Assumes ref_clk at 100 MHz.
`include "pwm_consts.svh"
module count_source
  import pwm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Selection and pin
  input wire logic [2:0] src_sel,
  input wire logic external_count_clock,
  // Enable out
  output logic tick_r
);
  logic [4:0] div_r;
  logic [2:0] ext_sync_r;
  logic ext_lvl_r;
  logic ext_prev_r;
  logic tick_nxt;

  // Free-running divider
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      div_r <= 5'h00;
    end else begin
      div_r <= div_r + 5'h01;
    end
  end

  // Pin passes three flops; a level counts once stages two and three agree
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ext_sync_r <= 3'h0;
      ext_lvl_r <= 1'b0;
      ext_prev_r <= 1'b0;
    end else begin
      ext_sync_r <= {ext_sync_r[1:0], external_count_clock};
      if (ext_sync_r[1] == ext_sync_r[2]) begin
        ext_lvl_r <= ext_sync_r[2];
      end
      ext_prev_r <= ext_lvl_r;
    end
  end

  // Source select; forbidden codes give no enable at all
  always_comb begin
    unique case (src_sel)
      `CS_DIV1: tick_nxt = 1'b1;
      `CS_DIV2: tick_nxt = (div_r[0] == 1'b1);
      `CS_DIV4: tick_nxt = (div_r[1:0] == 2'h3);
      `CS_DIV8: tick_nxt = (div_r[2:0] == 3'h7);
      `CS_DIV32: tick_nxt = (div_r == 5'h1f);
      `CS_EXT: tick_nxt = ext_lvl_r & ~ext_prev_r;
      default: tick_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= tick_nxt;
    end
  end
endmodule

// *** design/pwm_consts.svh ***
// ----------------------------------------------------------------
// Constants of the complementary PWM output control block
// ----------------------------------------------------------------
// Holds register addresses, field positions, reset values and codes.
// Assumes an 8-bit register port with a 5-bit address.
`ifndef PWM_CONSTS_SVH
`define PWM_CONSTS_SVH
// Register addresses
`define A_FUNC_CTL 5'h00
`define A_CUT0 5'h01
`define A_CUT1 5'h02
`define A_OUT_DIS 5'h03
`define A_COUNT_CTL 5'h04
`define A_IRQ_EN 5'h05
`define A_RUN 5'h06
`define A_TMODE 5'h07
`define A_STATUS 5'h08
`define A_PERIOD_L 5'h09
`define A_PERIOD_H 5'h0a
`define A_CMPB_L 5'h0b
`define A_CMPB_H 5'h0c
`define A_BUFD_L 5'h0d
`define A_BUFD_H 5'h0e
`define A_DEAD_L 5'h0f
`define A_DEAD_H 5'h10
`define A_COUNT_L 5'h11
`define A_COUNT_H 5'h12
// Field positions
`define F_CPH_LVL 3
`define F_NPH_LVL 2
`define F_WRAP_IE 4
`define F_BUF_D0 5
`define F_LOCKSTEP 0
`define F_UP_FLAG 4
`define F_DOWN_FLAG 5
// Reset values
`define R_ZERO8 8'h00
`define R_OUT_DIS 8'hff
`define R_ZERO16 16'h0000
`define R_PERIOD 16'hffff
// Count source codes
`define CS_DIV1 3'h0
`define CS_DIV2 3'h1
`define CS_DIV4 3'h2
`define CS_DIV8 3'h3
`define CS_DIV32 3'h4
`define CS_EXT 3'h5
// Cutoff field codes
`define CUT_NONE 2'h0
`define CUT_HIZ 2'h1
`define CUT_LOW 2'h2
`define CUT_HIGH 2'h3
`endif

// *** design/pwm_pkg.sv ***
// ----------------------------------------------------------------
// Types of the complementary PWM output control block
// ----------------------------------------------------------------
// Holds the mode and state enumerations shared by the design.
// Assumes nothing of its surroundings.
package pwm_pkg;
  typedef enum logic [1:0] {
    MODE_TIMER = 2'h0,
    MODE_RSYNC = 2'h1,
    MODE_COMP_UNDER = 2'h2,
    MODE_COMP_MATCH = 2'h3
  } combo_mode_t;
  typedef enum logic [2:0] {
    ST_STOP = 3'b001,
    ST_UP = 3'b010,
    ST_DOWN = 3'b100
  } count_state_t;
endpackage

// *** tb/complementary_pwm_output_control_bench.sv ***
// ----------------------------------------------------------------
// Self-checking bench of the complementary PWM output control
// ----------------------------------------------------------------
// Drives the register port and the count clock pin, a gate driver model
// stands on the pins. Assumes the register map of pwm_consts.svh.
`include "pwm_consts.svh"
module complementary_pwm_output_control_bench
  import pwm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, rstn, wr, rd, ext_clk, trip;
  logic [4:0] addr;
  logic [7:0] wdata, rdata_r, pin_out_r, pin_oe_n_r, gpio_sel_r, d0, d1, p0;
  logic [3:0] match_irq_r;
  logic wrap_irq_r, cutoff_pin;
  logic [1:0] act_hi;
  logic [15:0] overlaps, edges;
  int fails = 0;
  int cmp_count = 0;
  int rate_exp [6] = '{64, 32, 16, 8, 2, 8};
  // ----------------------------------------------------------------
  // Design and partner
  // ----------------------------------------------------------------
  complementary_pwm_output_control complementary_pwm_output_control_inst (.ref_clk(ref_clk), .rstn(rstn),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r), .external_count_clock(ext_clk),
    .cutoff_pin(cutoff_pin), .pin_out_r(pin_out_r), .pin_oe_n_r(pin_oe_n_r), .gpio_sel_r(gpio_sel_r),
    .match_irq_r(match_irq_r), .wrap_irq_r(wrap_irq_r));
  gate_driver_model gate_driver_model_inst (.ref_clk(ref_clk), .rstn(rstn), .pin_out_r(pin_out_r),
    .pin_oe_n_r(pin_oe_n_r), .gpio_sel_r(gpio_sel_r), .act_hi(act_hi), .trip(trip),
    .cutoff_pin(cutoff_pin), .overlaps(overlaps), .edges(edges));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // One-cycle strobes with a gap, so no signal is assigned twice per step
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    rd <= 1'b1; addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata_r;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd_reg(a, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask
  // Bounded wait on one of the request lines, index 4 is the wrap request
  task automatic wait_irq(input int idx);
    logic [4:0] req;
    int n;
    req = {wrap_irq_r, match_irq_r};
    for (n = 0; n < 400 && req[idx] !== 1'b1; n++) begin
      @(posedge ref_clk);
      req = {wrap_irq_r, match_irq_r};
    end
    chk({15'h0000, req[idx]}, 16'h0001);
    // A request that never came ends the run here
    if (req[idx] !== 1'b1) begin
      conclude();
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, reset and watchdog
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Hang guard, far above the length of the run
  initial begin
    #900us;
    fails++;
    conclude();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0; wr = 1'b0; rd = 1'b0; addr = 5'h00; wdata = 8'h00;
    ext_clk = 1'b0; trip = 1'b0; act_hi = 2'b11;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    // Reset state and unmapped place
    chk({8'h00, gpio_sel_r}, 16'h00ff);
    rd_chk(`A_FUNC_CTL, 8'h00);
    rd_chk(`A_OUT_DIS, 8'hff);
    rd_chk(`A_IRQ_EN, 8'h00);
    rd_chk(5'h1f, 8'h00);
    // Lockstep start sets both run flags from one bit
    wr_reg(`A_TMODE, 8'h01);
    wr_reg(`A_RUN, 8'h01);
    rd_chk(`A_RUN, 8'h03);
    wr_reg(`A_RUN, 8'h00);
    rd_chk(`A_RUN, 8'h00);
    wr_reg(`A_TMODE, 8'h00);
    wr_reg(`A_RUN, 8'h01);
    // Count rate for every legal source, pin clock toggling throughout
    for (int c = 0; c < 6; c++) begin
      wr_reg(`A_COUNT_CTL, c[7:0]);
      rd_reg(`A_COUNT_L, d0);
      for (int i = 0; i < 62; i++) begin
        @(posedge ref_clk);
        ext_clk <= i[2];
      end
      rd_reg(`A_COUNT_L, d1);
      p0 = d1 - d0 - rate_exp[c][7:0] + 8'h01;
      chk({15'h0000, p0 <= 8'h02}, 16'h0001);
    end
    // Forbidden source code gives no count enable at all
    wr_reg(`A_COUNT_CTL, 8'h06);
    rd_reg(`A_COUNT_L, d0);
    repeat (20) @(posedge ref_clk);
    rd_chk(`A_COUNT_L, d0);
    // Stopped counter holds its value
    wr_reg(`A_RUN, 8'h00);
    rd_reg(`A_COUNT_L, d0);
    repeat (20) @(posedge ref_clk);
    rd_chk(`A_COUNT_L, d0);
    // Second reset brings the counter back below the short period used next
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    chk({8'h00, gpio_sel_r}, 16'h00ff);
    rd_chk(`A_COUNT_L, 8'h00);
    // Setup while stopped: cutoff fields, channel-0 A handed to I/O
    wr_reg(`A_COUNT_CTL, 8'h00);
    wr_reg(`A_CUT0, 8'h2d);
    wr_reg(`A_CUT1, 8'haa);
    wr_reg(`A_OUT_DIS, 8'h01);
    repeat (2) @(posedge ref_clk);
    chk({8'h00, gpio_sel_r}, 16'h0001);
    wr_reg(`A_PERIOD_L, 8'h28);
    wr_reg(`A_PERIOD_H, 8'h00);
    wr_reg(`A_CMPB_L, 8'h0a);
    wr_reg(`A_CMPB_H, 8'h00);
    wr_reg(`A_BUFD_L, 8'h14);
    wr_reg(`A_BUFD_H, 8'h00);
    wr_reg(`A_DEAD_L, 8'h03);
    wr_reg(`A_DEAD_H, 8'h00);
    wr_reg(`A_TMODE, 8'h20);
    // Level selects ignored in timer mode
    wr_reg(`A_FUNC_CTL, 8'h00);
    repeat (2) @(posedge ref_clk);
    p0 = pin_out_r;
    wr_reg(`A_FUNC_CTL, 8'h0c);
    repeat (2) @(posedge ref_clk);
    chk({8'h00, pin_out_r}, {8'h00, p0});
    // Initial outputs follow each level select on its own
    wr_reg(`A_FUNC_CTL, 8'h06);
    repeat (2) @(posedge ref_clk);
    chk({14'h0000, pin_out_r[3], pin_out_r[1]}, 16'h0002);
    wr_reg(`A_FUNC_CTL, 8'h09);
    repeat (2) @(posedge ref_clk);
    chk({14'h0000, pin_out_r[3], pin_out_r[1]}, 16'h0001);
    // Complementary run, transfer at underflow
    wr_reg(`A_FUNC_CTL, 8'h0e);
    wr_reg(`A_RUN, 8'h03);
    repeat (400) @(posedge ref_clk);
    rd_chk(`A_CMPB_L, 8'h14);
    // Transfer at period match with a new buffer value
    wr_reg(`A_BUFD_L, 8'h1e);
    wr_reg(`A_FUNC_CTL, 8'h0f);
    repeat (300) @(posedge ref_clk);
    rd_chk(`A_CMPB_L, 8'h1e);
    chk(overlaps, 16'h0000);
    chk({15'h0000, edges > 16'h0001}, 16'h0001);
    // Forced cutoff in mid-run, disable bit still wins on channel-0 A
    trip <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk({8'h00, pin_out_r[7:1], pin_oe_n_r[3]}, 16'h0005);
    chk({8'h00, pin_oe_n_r[7:4], pin_oe_n_r[2:1], gpio_sel_r[1:0]}, 16'h0001);
    trip <= 1'b0;
    repeat (10) @(posedge ref_clk);
    // Requests gated by their enables
    wr_reg(`A_IRQ_EN, 8'hff);
    rd_chk(`A_IRQ_EN, 8'h1f);
    wait_irq(4);
    wr_reg(`A_FUNC_CTL, 8'h00);
    wait_irq(0);
    wr_reg(`A_IRQ_EN, 8'h00);
    repeat (3) @(posedge ref_clk);
    chk({11'h000, wrap_irq_r, match_irq_r}, 16'h0000);
    conclude();
  end
endmodule

// *** tb/gate_driver_model.sv ***
// ----------------------------------------------------------------
// Gate driver stand-in for the three inverter legs
// ----------------------------------------------------------------
// Watches the eight timer pins like a power stage and raises the fault line.
// Assumes pins ordered A0 B0 C0 D0 A1 B1 C1 D1 and one 100 MHz clock.
module gate_driver_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Timer pins
  input wire logic [7:0] pin_out_r,
  input wire logic [7:0] pin_oe_n_r,
  input wire logic [7:0] gpio_sel_r,
  // Active levels, normal phase in bit 0, counter phase in bit 1
  input wire logic [1:0] act_hi,
  // Fault request from the bench
  input wire logic trip,
  output logic cutoff_pin,
  // Observations
  output logic [15:0] overlaps,
  output logic [15:0] edges
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] on;
  logic prev_b0;
  // A leg conducts only when driven, not handed to I/O, and at its active level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      on[i] = !pin_oe_n_r[i] && !gpio_sel_r[i] && (pin_out_r[i] == ((i == 1 || i == 4 || i == 5) ? act_hi[0] : act_hi[1]));
    end
  end
  // Fault line is a plain level, the stage latches nothing
  assign cutoff_pin = trip;
  // Shoot-through counter: both switches of one leg on in the same cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      overlaps <= 16'h0000;
      edges <= 16'h0000;
      prev_b0 <= 1'b0;
    end else begin
      if ((on[1] && on[3]) || (on[4] && on[6]) || (on[5] && on[7])) begin
        overlaps <= overlaps + 16'h0001;
      end
      prev_b0 <= on[1];
      if (on[1] && !prev_b0) begin
        edges <= edges + 16'h0001;
      end
    end
  end
endmodule
